//--- hdl/ecu_pkg.sv
/*
  Constants, types and shared helpers of the edge capture unit.
  Assumes a 40 MHz system clock and the parameter port of the unit.
*/
// Contract
// - Source code 0,1,3,4 selects trigger input
// - Edge 0 falling, 1 rising, 2 both
// - Ignore trigger for holdoff milliseconds after capture
// - Both edges keep separate holdoff windows
// - Repetitive capture inhibits only its own edge
// - Filter mode 0 symmetric, 1 asymmetric
// - Symmetric uses active threshold for both edges
// - Asymmetric uses restore threshold on restore edge
// - Thresholds are 32-bit unsigned, reset zero
// - State 0 stopped, triggers ignored, read-only
// - Single armed captures then goes single stop
// - Repetitive armed captures then goes repetitive done
// - Single stop ignores trigger, keeps results
// - Command 0 stop,1 single,2 repetitive,3 forced
// - Single results hold until rearm
// - Repetitive done overwrites; result read rearms
// - Done states report edge-specific codes
package ecu_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] ADDR_STATE = 16'h0af0;
  localparam logic [15:0] ADDR_CMD = 16'h0af1;
  localparam logic [15:0] ADDR_TRIG = 16'h0af2;
  localparam logic [15:0] ADDR_EDGE = 16'h0af3;
  localparam logic [15:0] ADDR_HOLD = 16'h0af4;
  localparam logic [15:0] ADDR_FMODE = 16'h0af9;
  localparam logic [15:0] ADDR_RESTORE = 16'h0afa;
  localparam logic [15:0] ADDR_ACTIVE = 16'h0afc;
  localparam logic [15:0] ADDR_RESULT = 16'h0b04;

  // ----------------------------------------
  // Reset values and ranges
  // ----------------------------------------
  localparam logic [2:0] RST_TRIG = 3'h0;
  localparam logic [1:0] RST_EDGE = 2'h0;
  localparam logic [15:0] RST_HOLD = 16'h0000;
  localparam logic RST_FMODE = 1'b0;
  localparam logic [31:0] RST_THRESH = 32'h0000_0000;
  localparam logic [15:0] HOLD_MAX_MS = 16'hffdc;

  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [2:0] TRG_IN9 = 3'h0;
  localparam logic [2:0] TRG_IN8 = 3'h1;
  localparam logic [2:0] TRG_FB_INDEX = 3'h3;
  localparam logic [2:0] TRG_MS_INDEX = 3'h4;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h0;
  localparam logic [1:0] CMD_SINGLE = 2'h1;
  localparam logic [1:0] CMD_REPEAT = 2'h2;
  localparam logic [1:0] CMD_FORCE = 2'h3;
  localparam logic [3:0] CODE_STOP = 4'h0;
  localparam logic [3:0] CODE_SARM = 4'h1;
  localparam logic [3:0] CODE_RARM = 4'h2;
  localparam logic [3:0] CODE_SDONE = 4'h3;
  localparam logic [3:0] CODE_RDONE = 4'h4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

  typedef enum logic [4:0] {
    ST_STOP = 5'h01,
    ST_SARM = 5'h02,
    ST_RARM = 5'h04,
    ST_SDONE = 5'h08,
    ST_RDONE = 5'h10
  } ecu_state_t;

  // Status word: base code in low nibble, edge tag above it
  function automatic logic [15:0] ecu_code(input logic [3:0] base, input logic [1:0] tag);
    ecu_code = {10'h000, tag, base};
  endfunction

endpackage

//--- hdl/ecu_hold_if.sv
/*
  Link between the capture controller and one holdoff window counter.
  Assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
interface ecu_hold_if;
  logic start;
  logic [15:0] load_ms;
  logic busy;
  modport ctl (output start, output load_ms, input busy);
  modport cnt (input start, input load_ms, output busy);
endinterface

//--- hdl/ecu_tick.sv
/*
  Millisecond tick generator.
  Assumes a free running sys_clk; ce freezes the count.
*/
`timescale 1ns/1ps
module ecu_tick #(
  parameter int TICK_CYC = ecu_pkg::TICK_CYC
) (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  output logic tick // One-cycle pulse each millisecond
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic wrap;

  assign wrap = (cnt_q == 32'(TICK_CYC - 1));
  assign cnt_d = wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_q <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      tick <= wrap;
    end
  end
endmodule

//--- hdl/ecu_holdoff.sv
/*
  Holdoff window counter for one edge polarity.
  Assumes a millisecond tick pulse from the tick generator.
*/
`timescale 1ns/1ps
module ecu_holdoff (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic tick, // Millisecond tick
  ecu_hold_if.cnt hif // Start, length and busy
);
  logic [16:0] left_q;
  logic [16:0] left_d;

  // One extra tick so a window never ends short of its length
  always_comb begin
    left_d = left_q;
    if (hif.start && hif.load_ms != 16'h0000) begin
      left_d = {1'b0, hif.load_ms} + 17'h00001;
    end else if (tick && left_q != 17'h00000) begin
      left_d = left_q - 17'h00001;
    end
  end

  assign hif.busy = (left_q != 17'h00000);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      left_q <= 17'h00000;
    end else if (ce) begin
      left_q <= left_d;
    end
  end
endmodule

//--- hdl/ecu_top.sv
/*
  Edge capture unit: trigger selection, edge qualification, per-edge
  holdoff, capture state machine and parameter registers.
  Assumes trigger inputs synchronous to sys_clk and a parameter port
  with one-cycle read and write strobes.
*/
`timescale 1ns/1ps
module ecu_top #(
  parameter int TICK_CYC = ecu_pkg::TICK_CYC
) (
  input wire logic sys_clk, // System clock, 40 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic digital_input_nine, // Digital input nine
  input wire logic digital_input_eight, // Digital input eight
  input wire logic fb_index, // Feedback encoder index pulse
  input wire logic master_index, // Master encoder index pulse
  input wire logic [31:0] qty_in, // First quantity to capture
  input wire logic [15:0] reg_addr, // Parameter address
  input wire logic reg_wr, // Parameter write strobe
  input wire logic reg_rd, // Parameter read strobe
  input wire logic [31:0] reg_wdata, // Parameter write data
  output logic [31:0] reg_rdata, // Parameter read data
  output logic capture_pulse, // One-cycle pulse per capture
  output logic [31:0] capture_value, // Last captured quantity
  output logic [31:0] capture_thresh, // Filter threshold, capture edge
  output logic [31:0] restore_thresh // Filter threshold, restore edge
);

  // ----------------------------------------
  // Parameter registers
  // ----------------------------------------
  logic [2:0] trig_sel_q;
  logic [1:0] edge_sel_q;
  logic [15:0] hold_ms_q;
  logic fmode_q;
  logic [31:0] restore_q;
  logic [31:0] active_q;
  logic [1:0] cmd_q;

  logic wr_trig;
  logic wr_edge;
  logic wr_hold;
  logic wr_fmode;
  logic wr_restore;
  logic wr_active;
  logic wr_cmd;
  logic rd_result;

  // Out-of-range writes are dropped and the old value stays
  assign wr_trig = reg_wr && reg_addr == ecu_pkg::ADDR_TRIG && reg_wdata[31:3] == 29'h0
    && reg_wdata[2:0] != 3'h2 && reg_wdata[2:0] <= ecu_pkg::TRG_MS_INDEX;
  assign wr_edge = reg_wr && reg_addr == ecu_pkg::ADDR_EDGE && reg_wdata[31:2] == 30'h0
    && reg_wdata[1:0] <= ecu_pkg::EDGE_BOTH;
  assign wr_hold = reg_wr && reg_addr == ecu_pkg::ADDR_HOLD && reg_wdata[31:16] == 16'h0
    && reg_wdata[15:0] <= ecu_pkg::HOLD_MAX_MS;
  assign wr_fmode = reg_wr && reg_addr == ecu_pkg::ADDR_FMODE && reg_wdata[31:1] == 31'h0;
  assign wr_restore = reg_wr && reg_addr == ecu_pkg::ADDR_RESTORE;
  assign wr_active = reg_wr && reg_addr == ecu_pkg::ADDR_ACTIVE;
  assign wr_cmd = reg_wr && reg_addr == ecu_pkg::ADDR_CMD && reg_wdata[31:2] == 30'h0;
  assign rd_result = reg_rd && reg_addr == ecu_pkg::ADDR_RESULT;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      trig_sel_q <= ecu_pkg::RST_TRIG;
      edge_sel_q <= ecu_pkg::RST_EDGE;
      hold_ms_q <= ecu_pkg::RST_HOLD;
      fmode_q <= ecu_pkg::RST_FMODE;
      restore_q <= ecu_pkg::RST_THRESH;
      active_q <= ecu_pkg::RST_THRESH;
      cmd_q <= ecu_pkg::CMD_STOP;
    end else if (ce) begin
      if (wr_trig) begin
        trig_sel_q <= reg_wdata[2:0];
      end
      if (wr_edge) begin
        edge_sel_q <= reg_wdata[1:0];
      end
      if (wr_hold) begin
        hold_ms_q <= reg_wdata[15:0];
      end
      if (wr_fmode) begin
        fmode_q <= reg_wdata[0];
      end
      if (wr_restore) begin
        restore_q <= reg_wdata;
      end
      if (wr_active) begin
        active_q <= reg_wdata;
      end
      if (wr_cmd) begin
        cmd_q <= reg_wdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Validation filter thresholds
  // ----------------------------------------
  assign capture_thresh = active_q;
  assign restore_thresh = fmode_q ? restore_q : active_q;

  // ----------------------------------------
  // Trigger source and edge detection
  // ----------------------------------------
  logic trig_now;
  logic trig_prev_q;
  logic rise_raw;
  logic fall_raw;

  assign trig_now = (trig_sel_q == ecu_pkg::TRG_IN9) ? digital_input_nine :
    (trig_sel_q == ecu_pkg::TRG_IN8) ? digital_input_eight :
    (trig_sel_q == ecu_pkg::TRG_FB_INDEX) ? fb_index :
    (trig_sel_q == ecu_pkg::TRG_MS_INDEX) ? master_index : 1'b0;
  // A change of source compares the new line against the old one,
  // so differing levels on the two lines read as one edge
  assign rise_raw = trig_now && !trig_prev_q;
  assign fall_raw = !trig_now && trig_prev_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      trig_prev_q <= 1'b0;
    end else if (ce) begin
      trig_prev_q <= trig_now;
    end
  end

  // ----------------------------------------
  // Holdoff windows, one per polarity
  // ----------------------------------------
  logic tick;
  // Rearming leaves running windows alone
  ecu_hold_if fall_hif ();
  ecu_hold_if rise_hif ();

  ecu_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .tick(tick)
  );

  ecu_holdoff u_fall_hold (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .tick(tick),
    .hif(fall_hif.cnt)
  );

  ecu_holdoff u_rise_hold (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .tick(tick),
    .hif(rise_hif.cnt)
  );

  // ----------------------------------------
  // Qualified trigger
  // ----------------------------------------
  ecu_pkg::ecu_state_t state_q;
  ecu_pkg::ecu_state_t state_d;
  logic armed;
  logic fall_ok;
  logic rise_ok;
  logic force_trig;
  logic hit;
  logic [1:0] hit_tag;

  assign armed = (state_q == ecu_pkg::ST_SARM) || (state_q == ecu_pkg::ST_RARM)
    || (state_q == ecu_pkg::ST_RDONE);
  assign fall_ok = fall_raw && edge_sel_q != ecu_pkg::EDGE_RISE && !fall_hif.busy;
  assign rise_ok = rise_raw && edge_sel_q != ecu_pkg::EDGE_FALL && !rise_hif.busy;
  assign force_trig = wr_cmd && reg_wdata[1:0] == ecu_pkg::CMD_FORCE;
  // A command write wins over a trigger in the same cycle; that edge is lost
  assign hit = armed && (fall_ok || rise_ok) && !wr_cmd;

  // Each window starts only on its own edge
  assign fall_hif.start = ce && hit && fall_ok;
  assign rise_hif.start = ce && hit && rise_ok;
  assign fall_hif.load_ms = hold_ms_q;
  assign rise_hif.load_ms = hold_ms_q;

  // Edge tag: 1 falling, 2 rising, 3 both (single or forced capture on both edges)
  assign hit_tag = (state_q == ecu_pkg::ST_SARM || force_trig) ? edge_sel_q + 2'h1
    : (rise_ok ? 2'h2 : 2'h1);

  // ----------------------------------------
  // Capture state machine
  // ----------------------------------------
  logic [1:0] tag_q;
  logic [1:0] tag_d;
  logic take;

  always_comb begin
    state_d = state_q;
    tag_d = tag_q;
    take = 1'b0;
    if (wr_cmd) begin
      tag_d = 2'h0;
      case (reg_wdata[1:0])
        ecu_pkg::CMD_STOP: begin
          state_d = ecu_pkg::ST_STOP;
        end
        ecu_pkg::CMD_SINGLE: begin
          state_d = ecu_pkg::ST_SARM;
        end
        ecu_pkg::CMD_REPEAT: begin
          state_d = ecu_pkg::ST_RARM;
        end
        ecu_pkg::CMD_FORCE: begin
          state_d = ecu_pkg::ST_SDONE;
          tag_d = hit_tag;
          take = 1'b1;
        end
        default: begin
          state_d = ecu_pkg::ST_STOP;
        end
      endcase
    end else begin
      case (state_q)
        ecu_pkg::ST_STOP: begin
          state_d = ecu_pkg::ST_STOP;
        end
        ecu_pkg::ST_SARM: begin
          if (hit) begin
            state_d = ecu_pkg::ST_SDONE;
            tag_d = hit_tag;
            take = 1'b1;
          end
        end
        ecu_pkg::ST_RARM: begin
          if (hit) begin
            state_d = ecu_pkg::ST_RDONE;
            tag_d = hit_tag;
            take = 1'b1;
          end
        end
        ecu_pkg::ST_SDONE: begin
          state_d = ecu_pkg::ST_SDONE;
        end
        ecu_pkg::ST_RDONE: begin
          if (hit) begin
            tag_d = hit_tag;
            take = 1'b1;
          // A capture in the same cycle as a result read wins
          end else if (rd_result) begin
            state_d = ecu_pkg::ST_RARM;
            tag_d = 2'h0;
          end
        end
        default: begin
          state_d = ecu_pkg::ST_STOP;
          tag_d = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= ecu_pkg::ST_STOP;
      tag_q <= 2'h0;
    end else if (ce) begin
      state_q <= state_d;
      tag_q <= tag_d;
    end
  end

  // ----------------------------------------
  // Captured result
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      capture_value <= 32'h0000_0000;
      capture_pulse <= 1'b0;
    end else if (ce) begin
      capture_pulse <= take;
      if (take) begin
        capture_value <= qty_in;
      end
    end
  end

  // ----------------------------------------
  // Status code and read port
  // ----------------------------------------
  logic [3:0] base_code;
  logic [15:0] state_code;
  logic [31:0] rdata_d;

  assign base_code = (state_q == ecu_pkg::ST_SARM) ? ecu_pkg::CODE_SARM :
    (state_q == ecu_pkg::ST_RARM) ? ecu_pkg::CODE_RARM :
    (state_q == ecu_pkg::ST_SDONE) ? ecu_pkg::CODE_SDONE :
    (state_q == ecu_pkg::ST_RDONE) ? ecu_pkg::CODE_RDONE : ecu_pkg::CODE_STOP;
  // Armed states carry tag 0, done states the edge tag of the last capture
  assign state_code = ecu_pkg::ecu_code(base_code, tag_q);

  always_comb begin
    case (reg_addr)
      ecu_pkg::ADDR_STATE: begin
        rdata_d = {16'h0000, state_code};
      end
      ecu_pkg::ADDR_CMD: begin
        rdata_d = {30'h0, cmd_q};
      end
      ecu_pkg::ADDR_TRIG: begin
        rdata_d = {29'h0, trig_sel_q};
      end
      ecu_pkg::ADDR_EDGE: begin
        rdata_d = {30'h0, edge_sel_q};
      end
      ecu_pkg::ADDR_HOLD: begin
        rdata_d = {16'h0000, hold_ms_q};
      end
      ecu_pkg::ADDR_FMODE: begin
        rdata_d = {31'h0, fmode_q};
      end
      ecu_pkg::ADDR_RESTORE: begin
        rdata_d = restore_q;
      end
      ecu_pkg::ADDR_ACTIVE: begin
        rdata_d = active_q;
      end
      ecu_pkg::ADDR_RESULT: begin
        rdata_d = capture_value;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce && reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

//--- verif/ecu_trig_model.sv
/*
  Trigger source model: four level lines standing in for the two
  digital inputs and the two encoder index pulses.
  Assumes the bench moves src_sel and lvl just after a falling edge.
*/
`timescale 1ns/1ps
module ecu_trig_model (
  input wire logic [2:0] src_sel, // Line to move, by source code
  input wire logic lvl, // Level for that line
  output logic digital_input_nine, // Source code 0
  output logic digital_input_eight, // Source code 1
  output logic fb_index, // Source code 3
  output logic master_index // Source code 4
);
  logic [4:0] line_q = 5'h00;

  // Unselected lines keep their last level, as real inputs do
  always @(src_sel, lvl) line_q[src_sel] = lvl;
  assign digital_input_nine = line_q[0];
  assign digital_input_eight = line_q[1];
  assign fb_index = line_q[3];
  assign master_index = line_q[4];
endmodule

//--- verif/ecu_top_assertions.sv
/*
  Port checker of the edge capture unit.
  Assumes it is bound to ecu_top and sees only its ports.
*/
`timescale 1ns/1ps
module ecu_top_assertions #(
  parameter int TICK_CYC = 40000
) (
  input wire logic sys_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic digital_input_nine, // Source 0
  input wire logic digital_input_eight, // Source 1
  input wire logic fb_index, // Source 3
  input wire logic master_index, // Source 4
  input wire logic [31:0] qty_in, // Quantity
  input wire logic [15:0] reg_addr, // Address
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic capture_pulse, // Capture pulse
  input wire logic [31:0] capture_value, // Captured value
  input wire logic [31:0] capture_thresh, // Capture threshold
  input wire logic [31:0] restore_thresh // Restore threshold
);
  // ----------------------------------------
  // Shadow of filter mode and stop state
  // ----------------------------------------
  wire wr_en = ce && reg_wr;
  wire cmd_wr = wr_en && reg_addr == ecu_pkg::ADDR_CMD;
  logic mode_q;
  logic stop_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) mode_q <= 1'b0;
    else if (wr_en && reg_addr == ecu_pkg::ADDR_FMODE && reg_wdata <= 32'h1) mode_q <= reg_wdata[0];
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) stop_q <= 1'b1;
    else if (cmd_wr && reg_wdata <= 32'h3) stop_q <= reg_wdata == 32'h0;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_reset_clears: assert property (disable iff (1'b0) !rstn |=> reg_rdata == 32'h0 && !capture_pulse)
    else $error("Outputs not cleared by reset");
  a_stop_quiet: assert property (stop_q |-> !capture_pulse)
    else $error("Capture while stopped");
  a_force_takes: assert property (cmd_wr && reg_wdata == 32'h3 |=> capture_pulse && capture_value == $past(qty_in))
    else $error("Forced capture missing");
  a_value_pulse: assert property (!$stable(capture_value) |-> capture_pulse)
    else $error("Captured value moved without a capture");
  a_active_thresh: assert property (wr_en && reg_addr == ecu_pkg::ADDR_ACTIVE |=> capture_thresh == $past(reg_wdata))
    else $error("Active threshold not applied");
  a_sym_thresh: assert property (!mode_q |-> restore_thresh == capture_thresh)
    else $error("Symmetric mode uses wrong threshold");
  a_asym_thresh: assert property (mode_q && wr_en && reg_addr == ecu_pkg::ADDR_RESTORE |=> restore_thresh == $past(reg_wdata))
    else $error("Asymmetric mode uses wrong threshold");
  a_mode_read: assert property (ce && reg_rd && reg_addr == ecu_pkg::ADDR_FMODE |=> reg_rdata == {31'h0, $past(mode_q)})
    else $error("Filter mode reads wrong");
endmodule

bind ecu_top ecu_top_assertions #(.TICK_CYC(TICK_CYC)) u_chk (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
  .digital_input_nine(digital_input_nine), .digital_input_eight(digital_input_eight), .fb_index(fb_index),
  .master_index(master_index), .qty_in(qty_in), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .capture_pulse(capture_pulse), .capture_value(capture_value),
  .capture_thresh(capture_thresh), .restore_thresh(restore_thresh));

//--- verif/test_edge_capture_unit.sv
/*
  Self-checking bench of the edge capture unit.
  Assumes the trigger model and the bound port checker.
*/
`timescale 1ns/1ps
module test_edge_capture_unit;
  localparam int TICK = 10;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] qty_in = 32'h0;
  logic [2:0] src_sel = 3'h0;
  logic lvl = 1'b0;
  logic [31:0] reg_rdata, capture_value, capture_thresh, restore_thresh;
  logic capture_pulse, digital_input_nine, digital_input_eight, fb_index, master_index;
  int err_count = 0;
  int total_checks = 0;
  int pulses = 0;
  int cyc = 0;

  always #12.5 sys_clk = ~sys_clk;

  ecu_trig_model u_model (.src_sel(src_sel), .lvl(lvl), .digital_input_nine(digital_input_nine),
    .digital_input_eight(digital_input_eight), .fb_index(fb_index), .master_index(master_index));
  ecu_top #(.TICK_CYC(TICK)) dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .digital_input_nine(digital_input_nine), .digital_input_eight(digital_input_eight), .fb_index(fb_index),
    .master_index(master_index), .qty_in(qty_in), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .capture_pulse(capture_pulse), .capture_value(capture_value),
    .capture_thresh(capture_thresh), .restore_thresh(restore_thresh));

  // ----------------------------------------
  // Pulse count, timeout and shared tasks
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (capture_pulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask

  // Moves the selected line and counts the captures that follow
  task automatic drive(input logic v, input logic [31:0] q, input int n);
    int p0;
    p0 = pulses;
    @(negedge sys_clk);
    qty_in = q;
    lvl = v;
    repeat (3) @(negedge sys_clk);
    chk(32'(pulses - p0), 32'(n));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] adr [7] = '{16'h0af0, 16'h0af2, 16'h0af3, 16'h0af4, 16'h0af9, 16'h0afa, 16'h0afc};
    foreach (adr[i]) rd(adr[i], 32'h0);
    wr(ecu_pkg::ADDR_STATE, 32'h3);
    rd(ecu_pkg::ADDR_STATE, 32'h0);
  endtask

  task automatic t_sources();
    logic [2:0] code [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    wr(ecu_pkg::ADDR_EDGE, 32'h1);
    foreach (code[i]) begin
      src_sel = code[i];
      wr(ecu_pkg::ADDR_TRIG, 32'(code[i]));
      wr(ecu_pkg::ADDR_CMD, 32'h2);
      drive(1'b1, 32'h400 + 32'(i), 1);
      wr(ecu_pkg::ADDR_CMD, 32'h0);
      drive(1'b0, 32'h0, 0);
    end
    wr(ecu_pkg::ADDR_TRIG, 32'h2);
    rd(ecu_pkg::ADDR_TRIG, 32'h4);
    src_sel = 3'h0;
    wr(ecu_pkg::ADDR_TRIG, 32'h0);
  endtask

  task automatic t_single();
    for (int pol = 0; pol < 3; pol++) begin
      wr(ecu_pkg::ADDR_EDGE, 32'(pol));
      wr(ecu_pkg::ADDR_CMD, 32'h1);
      rd(ecu_pkg::ADDR_STATE, 32'h1);
      drive(1'b1, 32'h100 + 32'(pol), int'(pol != 0));
      drive(1'b0, 32'h200 + 32'(pol), int'(pol == 0));
      rd(ecu_pkg::ADDR_STATE, 32'(16 * pol + 19));
      rd(ecu_pkg::ADDR_RESULT, pol == 0 ? 32'h200 : 32'h100 + 32'(pol));
      rd(ecu_pkg::ADDR_STATE, 32'(16 * pol + 19));
    end
    wr(ecu_pkg::ADDR_CMD, 32'h0);
  endtask

  task automatic t_force();
    wr(ecu_pkg::ADDR_EDGE, 32'h2);
    qty_in = 32'h0000_5a5a;
    wr(ecu_pkg::ADDR_CMD, 32'h3);
    rd(ecu_pkg::ADDR_STATE, 32'h33);
    rd(ecu_pkg::ADDR_RESULT, 32'h0000_5a5a);
    wr(ecu_pkg::ADDR_CMD, 32'h0);
    rd(ecu_pkg::ADDR_STATE, 32'h0);
    wr(ecu_pkg::ADDR_CMD, 32'h7);
    rd(ecu_pkg::ADDR_CMD, 32'h0);
  endtask

  task automatic t_filter();
    wr(ecu_pkg::ADDR_ACTIVE, 32'h1234_5678);
    wr(ecu_pkg::ADDR_RESTORE, 32'h0abc_def0);
    chk(capture_thresh, 32'h1234_5678);
    chk(restore_thresh, 32'h1234_5678);
    wr(ecu_pkg::ADDR_FMODE, 32'h1);
    wr(ecu_pkg::ADDR_RESTORE, 32'hffff_fffe);
    chk(restore_thresh, 32'hffff_fffe);
    wr(ecu_pkg::ADDR_FMODE, 32'h2);
    rd(ecu_pkg::ADDR_FMODE, 32'h1);
    rd(16'h0af5, 32'h0);
    wr(ecu_pkg::ADDR_FMODE, 32'h0);
    chk(restore_thresh, 32'h1234_5678);
  endtask

  task automatic t_repeat();
    src_sel = 3'h1;
    wr(ecu_pkg::ADDR_TRIG, 32'h1);
    wr(ecu_pkg::ADDR_EDGE, 32'h2);
    wr(ecu_pkg::ADDR_HOLD, 32'h2);
    wr(ecu_pkg::ADDR_HOLD, 32'(65501));
    rd(ecu_pkg::ADDR_HOLD, 32'h2);
    wr(ecu_pkg::ADDR_CMD, 32'h2);
    rd(ecu_pkg::ADDR_STATE, 32'h2);
    drive(1'b1, 32'h300, 1);
    rd(ecu_pkg::ADDR_STATE, 32'h24);
    drive(1'b0, 32'h301, 1);
    rd(ecu_pkg::ADDR_STATE, 32'h14);
    drive(1'b1, 32'h302, 0);
    rd(ecu_pkg::ADDR_RESULT, 32'h301);
    rd(ecu_pkg::ADDR_STATE, 32'h2);
    repeat (4 * TICK) @(negedge sys_clk);
    drive(1'b0, 32'h303, 1);
    drive(1'b1, 32'h304, 1);
    wr(ecu_pkg::ADDR_CMD, 32'h0);
    drive(1'b0, 32'h305, 0);
  endtask

  // Clock enable low freezes the registers; a mid-run reset clears them
  task automatic t_freeze();
    ce = 1'b0;
    wr(ecu_pkg::ADDR_EDGE, 32'h1);
    ce = 1'b1;
    rd(ecu_pkg::ADDR_EDGE, 32'h2);
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    rd(ecu_pkg::ADDR_EDGE, 32'h0);
    rd(ecu_pkg::ADDR_HOLD, 32'h0);
    rd(ecu_pkg::ADDR_STATE, 32'h0);
  endtask

  initial begin
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    t_reset();
    t_sources();
    t_single();
    t_force();
    t_filter();
    t_repeat();
    t_freeze();
    complete_run();
  end
endmodule
